// ===== hw/obc_loader.sv
/*
 * obc_loader: loads the option bytes after reset, times the reset phase,
 * holds decoded settings, and gates programmer access to the bytes.
 * Assumes: cell array read data follows cell_sel within the same cycle;
 * programmer command port runs on clk; prog_mode and test_mode are pins.
 */
// How it works
// RULE_01: bytes have no address; programmer reaches them only in prog mode.
// RULE_02: erased bytes read FFh so every option defaults to one.
// RULE_03: halt_watchdog_reset_opt one: halt with watchdog active resets.
// RULE_04: watchdog_type_opt zero forces the watchdog on in hardware.
// RULE_05: clock_source_select zero picks pll, one picks oscillator.
// RULE_06: voltage_detect_select 00 both detectors, 01 low only, else none.
// RULE_07: reset_cycle_select zero gives 4096 cycles, one gives 256.
// RULE_08: pll source forces 4096 cycle reset phase.
// RULE_09: programmer should pick 4096 cycles for resonators.
// RULE_10: input_halver zero halves the oscillator input, one bypasses.
// RULE_11: readout_protect zero enables protection, one disables.
// RULE_12: protection blocks program memory access in test and prog modes.
// RULE_13: erasing bytes while protected first wipes all user program memory.
// RULE_14: package_select 000 is 32 pin, 001 is 44 pin, rest reserved.
// RULE_15: motor_output_reset_state 00/11 float, 01 low, 10 high in reset.
// RULE_16: bytes sampled in reset, settings frozen until next reset.
`timescale 1ns/10ps
module obc_loader (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              prog_mode_pin,
   input  wire logic              test_mode_pin,
   input  wire logic              prog_req,
   input  wire obc_pkg::obc_cmd_e prog_cmd,
   input  wire logic              prog_sel,
   input  wire logic [7:0]        prog_wdata,
   output logic                   prog_ack,
   output logic                   prog_err,
   output logic [7:0]             prog_rdata,
   output logic                   cell_sel,
   output logic                   cell_we,
   output logic [7:0]             cell_wdata,
   input  wire logic [7:0]        cell_rdata,
   output logic                   mem_wipe_req,
   input  wire logic              mem_wipe_done,
   output logic                   mem_access_block,
   output logic                   reset_phase,
   output logic                   halt_watchdog_reset_opt,
   output logic                   watchdog_type_opt,
   output logic                   clock_source_select,
   output logic                   low_voltage_detector,
   output logic                   aux_voltage_detector,
   output logic                   reset_cycle_select,
   output logic                   input_halver,
   output logic                   readout_protect,
   output logic [2:0]             package_select,
   output logic                   package_reserved,
   output logic                   motor_output_oe,
   output logic                   motor_output_level,
   input  wire logic              halt_entry,
   input  wire logic              watchdog_active,
   output logic                   halt_reset_req
);
   import obc_pkg::*;

   typedef enum logic [8:0] {
      ST_LD0  = 9'h001,
      ST_LD1  = 9'h002,
      ST_RPH  = 9'h004,
      ST_IDLE = 9'h008,
      ST_RD   = 9'h010,
      ST_ECHK = 9'h020,
      ST_WIPE = 9'h040,
      ST_ER0  = 9'h080,
      ST_ER1  = 9'h100
   } obc_state_e;

   typedef struct packed {
      obc_state_e       st;
      logic [7:0]       b0;
      logic [7:0]       b1;
      logic [CNT_W-1:0] cnt;
      logic             pm_s1;
      logic             pm_s2;
      logic             tm_s1;
      logic             tm_s2;
      logic             sel;
      logic             we;
      logic [7:0]       wdata;
      logic             ack;
      logic             err;
      logic [7:0]       rdata;
      logic             wipe;
      logic             block;
      logic             rph;
      logic             halt_rst;
      logic [17:0]      cfg;
   } obc_state_s;

   obc_state_s state_reg;
   obc_state_s state_next;
   obc_opt_if  opt ();

   // phase length minus one, chosen by decoded setting
   function automatic logic [CNT_W-1:0] rph_load(input logic long_sel);
      rph_load = long_sel ? CNT_W'(RPH_LONG - 1) : CNT_W'(RPH_SHORT - 1);
   endfunction : rph_load

   assign opt.byte0 = state_reg.b0;
   assign opt.byte1 = state_reg.b1;

   obc_decode u_decode (
      .opt (opt)
   );

   // next state of the whole block
   always_comb begin
      state_next       = state_reg;
      state_next.pm_s1 = prog_mode_pin;
      state_next.pm_s2 = state_reg.pm_s1;
      state_next.tm_s1 = test_mode_pin;
      state_next.tm_s2 = state_reg.tm_s1;
      state_next.ack   = 1'b0;
      state_next.err   = 1'b0;
      state_next.we    = 1'b0;
      // decoded settings follow the frozen bytes
      state_next.cfg   = {opt.halt_rst_en, opt.wdg_hw_en, opt.clk_pll,
                          opt.lvd_en, opt.avd_en, opt.long_delay,
                          opt.halver_en, opt.protect_en, opt.package_select,
                          opt.pkg_reserved, opt.mco_oe, opt.mco_level,
                          4'h0};
      state_next.block = opt.protect_en &
                         (state_reg.tm_s2 | state_reg.pm_s2); // [RULE_12]
      state_next.halt_rst = halt_entry & watchdog_active &
                            opt.halt_rst_en;                  // [RULE_03]
      unique case (state_reg.st)
         // sample both bytes right after reset release
         ST_LD0: begin
            state_next.b0  = cell_rdata;                      // [RULE_16]
            state_next.sel = 1'b1;
            state_next.st  = ST_LD1;
         end
         ST_LD1: begin
            state_next.b1  = cell_rdata;                      // [RULE_16]
            state_next.st  = ST_RPH;
            state_next.cnt = rph_load(~state_reg.b0[B0_RST_CYC] |
                                      ~state_reg.b0[B0_CLK_SRC]); // [RULE_07] [RULE_08]
         end
         // count out the reset phase
         ST_RPH: begin
            if (state_reg.cnt == '0) begin
               state_next.rph = 1'b0;
               state_next.st  = ST_IDLE;
            end else begin
               state_next.cnt = state_reg.cnt - CNT_W'(1);
            end
         end
         // programmer access only in programming mode
         ST_IDLE: begin
            if (prog_req && !state_reg.pm_s2) begin
               state_next.err = 1'b1;                         // [RULE_01]
            end else if (prog_req) begin
               state_next.sel = prog_sel;
               unique case (prog_cmd)
                  OBC_CMD_READ: state_next.st = ST_RD;
                  OBC_CMD_WRITE: begin
                     state_next.we    = 1'b1;
                     state_next.wdata = prog_wdata;
                     state_next.ack   = 1'b1;
                  end
                  OBC_CMD_ERASE: begin
                     state_next.sel = 1'b0;
                     state_next.st  = ST_ECHK;
                  end
                  default: state_next.err = 1'b1;
               endcase
            end
         end
         ST_RD: begin
            state_next.rdata = cell_rdata;
            state_next.ack   = 1'b1;
            state_next.st    = ST_IDLE;
         end
         // live protection bit decides the wipe
         ST_ECHK: begin
            if (!cell_rdata[B0_PROTECT]) begin
               state_next.wipe = 1'b1;                        // [RULE_13]
               state_next.st   = ST_WIPE;
            end else begin
               state_next.st   = ST_ER0;
            end
         end
         ST_WIPE: begin
            if (mem_wipe_done) begin
               state_next.wipe = 1'b0;
               state_next.st   = ST_ER0;                      // [RULE_13]
            end
         end
         // erased bytes read back as all ones
         ST_ER0: begin
            state_next.we    = 1'b1;
            state_next.sel   = 1'b0;
            state_next.wdata = BYTE_ERASED;                   // [RULE_02]
            state_next.st    = ST_ER1;
         end
         ST_ER1: begin
            state_next.we    = 1'b1;
            state_next.sel   = 1'b1;
            state_next.wdata = BYTE_ERASED;                   // [RULE_02]
            state_next.ack   = 1'b1;
            state_next.st    = ST_IDLE;
         end
         default: state_next.st = ST_IDLE;
      endcase
      // motor pins driven per option only in reset phase
      state_next.cfg[5] = opt.mco_oe & state_next.rph;       // [RULE_15]
      state_next.cfg[4] = opt.mco_level & state_next.rph;    // [RULE_15]
   end

   // single state register, defaults match erased bytes
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg       <= '0;
         state_reg.st    <= ST_LD0;
         state_reg.b0    <= BYTE_ERASED;                      // [RULE_02]
         state_reg.b1    <= BYTE_ERASED;                      // [RULE_02]
         state_reg.wdata <= BYTE_ERASED;
         state_reg.rph   <= 1'b1;
         state_reg.cfg   <= {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                             1'b0, 1'b0, 3'h7, 1'b1, 1'b0, 1'b0, 4'h0};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign prog_ack                = state_reg.ack;
   assign prog_err                = state_reg.err;
   assign prog_rdata              = state_reg.rdata;
   assign cell_sel                = state_reg.sel;
   assign cell_we                 = state_reg.we;
   assign cell_wdata              = state_reg.wdata;
   assign mem_wipe_req            = state_reg.wipe;
   assign mem_access_block        = state_reg.block;
   assign reset_phase             = state_reg.rph;
   assign halt_reset_req          = state_reg.halt_rst;
   assign halt_watchdog_reset_opt = state_reg.cfg[17];
   assign watchdog_type_opt       = state_reg.cfg[16]; // high: hw forced
   assign clock_source_select     = state_reg.cfg[15]; // high: pll
   assign low_voltage_detector    = state_reg.cfg[14];
   assign aux_voltage_detector    = state_reg.cfg[13];
   assign reset_cycle_select      = state_reg.cfg[12]; // high: 4096
   assign input_halver            = state_reg.cfg[11]; // high: halving
   assign readout_protect         = state_reg.cfg[10]; // high: protected
   assign package_select          = state_reg.cfg[9:7];
   assign package_reserved        = state_reg.cfg[6];
   // motor pins, gated by reset phase before the flop
   assign motor_output_oe         = state_reg.cfg[5]; // [RULE_15]
   assign motor_output_level      = state_reg.cfg[4]; // [RULE_15]
endmodule : obc_loader

// ===== hw/obc_pkg.sv
/*
 * obc_pkg: shared constants for the configuration byte loader/decoder.
 * Assumes: option bytes live in an external non-volatile cell array.
 */
package obc_pkg;
   // byte widths and erased content
   localparam int          BYTE_W      = 8;
   localparam logic [7:0]  BYTE_ERASED = 8'hFF;
   // byte zero field positions
   localparam int          B0_HALT_RST = 7;
   localparam int          B0_WDG_TYPE = 6;
   localparam int          B0_CLK_SRC  = 5;
   localparam int          B0_VD_HI    = 4;
   localparam int          B0_VD_LO    = 3;
   localparam int          B0_RST_CYC  = 2;
   localparam int          B0_HALVER   = 1;
   localparam int          B0_PROTECT  = 0;
   // byte one field positions
   localparam int          B1_PKG_HI   = 7;
   localparam int          B1_PKG_LO   = 5;
   localparam int          B1_MCO_HI   = 1;
   localparam int          B1_MCO_LO   = 0;
   // field encodings
   localparam logic [1:0]  VD_BOTH_ON  = 2'h0;
   localparam logic [1:0]  VD_LOW_ONLY = 2'h1;
   localparam logic [2:0]  PKG_PIN32   = 3'h0;
   localparam logic [2:0]  PKG_PIN44   = 3'h1;
   localparam logic [1:0]  MCO_DRV_LOW = 2'h1;
   localparam logic [1:0]  MCO_DRV_HI  = 2'h2;
   // reset phase lengths in cpu cycles
   localparam int          RPH_LONG    = 4096;
   localparam int          RPH_SHORT   = 256;
   localparam int          CNT_W       = 13;
   // programmer commands
   typedef enum logic [1:0] {
      OBC_CMD_READ  = 2'h0,
      OBC_CMD_WRITE = 2'h1,
      OBC_CMD_ERASE = 2'h2
   } obc_cmd_e;
endpackage : obc_pkg

// ===== hw/obc_opt_if.sv
/*
 * obc_opt_if: latched option bytes and their decoded settings.
 * Assumes: loader drives bytes, decoder answers combinationally.
 */
`timescale 1ns/10ps
interface obc_opt_if;
   logic [7:0] byte0;
   logic [7:0] byte1;
   logic       halt_rst_en;
   logic       wdg_hw_en;
   logic       clk_pll;
   logic       lvd_en;
   logic       avd_en;
   logic       long_delay;
   logic       halver_en;
   logic       protect_en;
   logic [2:0] package_select;
   logic       pkg_reserved;
   logic       mco_oe;
   logic       mco_level;
   modport loader (output byte0, byte1,
                   input  halt_rst_en, wdg_hw_en, clk_pll, lvd_en, avd_en,
                          long_delay, halver_en, protect_en, package_select,
                          pkg_reserved, mco_oe, mco_level);
   modport decoder (input  byte0, byte1,
                    output halt_rst_en, wdg_hw_en, clk_pll, lvd_en, avd_en,
                           long_delay, halver_en, protect_en, package_select,
                           pkg_reserved, mco_oe, mco_level);
endinterface : obc_opt_if

// ===== hw/obc_decode.sv
/*
 * obc_decode: pure decode of the two option bytes into settings.
 * Assumes: bytes are held stable by the loader between resets.
 */
`timescale 1ns/10ps
module obc_decode (
   obc_opt_if.decoder opt
);
   import obc_pkg::*;

   logic [1:0] vd;
   logic [1:0] motor_output_reset_state;

   // field decode of byte zero
   always_comb begin
      vd              = opt.byte0[B0_VD_HI:B0_VD_LO];
      opt.halt_rst_en = opt.byte0[B0_HALT_RST];        // [RULE_03]
      opt.wdg_hw_en   = ~opt.byte0[B0_WDG_TYPE];       // [RULE_04]
      opt.clk_pll     = ~opt.byte0[B0_CLK_SRC];        // [RULE_05]
      opt.lvd_en      = (vd == VD_BOTH_ON) || (vd == VD_LOW_ONLY); // [RULE_06]
      opt.avd_en      = (vd == VD_BOTH_ON);            // [RULE_06]
      // pll source forces the long phase
      opt.long_delay  = ~opt.byte0[B0_RST_CYC] | ~opt.byte0[B0_CLK_SRC]; // [RULE_07] [RULE_08]
      opt.halver_en   = ~opt.byte0[B0_HALVER];         // [RULE_10]
      opt.protect_en  = ~opt.byte0[B0_PROTECT];        // [RULE_11]
   end

   // field decode of byte one
   always_comb begin
      motor_output_reset_state                = opt.byte1[B1_MCO_HI:B1_MCO_LO];
      opt.package_select = opt.byte1[B1_PKG_HI:B1_PKG_LO];
      opt.pkg_reserved   = (opt.package_select != PKG_PIN32) &&
                           (opt.package_select != PKG_PIN44); // [RULE_14]
      opt.mco_oe         = (motor_output_reset_state == MCO_DRV_LOW) || (motor_output_reset_state == MCO_DRV_HI); // [RULE_15]
      opt.mco_level      = (motor_output_reset_state == MCO_DRV_HI);       // [RULE_15]
   end
endmodule : obc_decode

// ===== dv/obc_loader_assertions.sv
/* obc_loader_assertions: port checks for the option byte loader.
   assumes: bound to obc_loader, one clock, sync active-high rst. */
`timescale 1ns/10ps
module obc_loader_assertions (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              prog_req,
   input wire obc_pkg::obc_cmd_e prog_cmd,
   input wire logic              prog_ack,
   input wire logic              prog_err,
   input wire logic              cell_we,
   input wire logic              mem_wipe_req,
   input wire logic              mem_access_block,
   input wire logic              reset_phase,
   input wire logic              halt_watchdog_reset_opt,
   input wire logic              clock_source_select,
   input wire logic              reset_cycle_select,
   input wire logic              readout_protect,
   input wire logic [2:0]        package_select,
   input wire logic              package_reserved,
   input wire logic              motor_output_oe,
   input wire logic              halt_entry,
   input wire logic              watchdog_active,
   input wire logic              halt_reset_req
);
   import obc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // write taken in idle, answered on the next cycle
   sequence s_wr_take;
      prog_req && !reset_phase && prog_cmd == OBC_CMD_WRITE;
   endsequence
   sequence s_wr_done;
      (cell_we && prog_ack) || prog_err;
   endsequence
   wr_answer_a: assert property (s_wr_take |=> s_wr_done)
      else $error("write not answered in one cycle");
   phase_quiet_a: assert property (reset_phase |-> !prog_ack && !cell_we)
      else $error("byte access during reset phase");
   halt_cause_a: assert property (halt_reset_req |->
      $past(halt_entry && watchdog_active) && halt_watchdog_reset_opt)
      else $error("halt reset without cause");
   halt_fire_a: assert property (!reset_phase && halt_entry &&
      watchdog_active && halt_watchdog_reset_opt |=> halt_reset_req)
      else $error("halt reset missing");
   pll_long_a: assert property (!reset_phase && clock_source_select
      |-> reset_cycle_select) else $error("pll without long phase");
   pkg_res_a: assert property (!reset_phase |->
      package_reserved == (package_select > 3'h1))
      else $error("package reserved flag wrong");
   mco_float_a: assert property (!reset_phase |-> !motor_output_oe)
      else $error("motor outputs driven after reset phase");
   frozen_cfg_a: assert property (!reset_phase && !$past(reset_phase)
      |-> $stable({halt_watchdog_reset_opt, clock_source_select,
      readout_protect, package_select})) else $error("settings moved");
   block_prot_a: assert property (mem_access_block |-> readout_protect)
      else $error("access blocked while unprotected");
   wipe_hold_a: assert property (mem_wipe_req |-> !cell_we && !prog_ack)
      else $error("byte written before memory wipe ended");
endmodule : obc_loader_assertions

bind obc_loader obc_loader_assertions i_chk (
   .clk, .rst, .prog_req, .prog_cmd, .prog_ack, .prog_err, .cell_we,
   .mem_wipe_req, .mem_access_block, .reset_phase, .halt_watchdog_reset_opt,
   .clock_source_select, .reset_cycle_select, .readout_protect,
   .package_select, .package_reserved, .motor_output_oe, .halt_entry,
   .watchdog_active, .halt_reset_req
);

// ===== dv/obc_loader_tb_top.sv
/* obc_loader_tb_top: self-checking bench for the option byte loader.
   assumes: bench plays programmer, cell array and memory wiper. */
`timescale 1ns/10ps
module obc_loader_tb_top;
   import obc_pkg::*;
   logic       clk, rst, prog_mode_pin, test_mode_pin, prog_req, prog_sel;
   obc_cmd_e   prog_cmd;
   logic [7:0] prog_wdata, prog_rdata, cell_wdata, cell_rdata;
   logic       prog_ack, prog_err, cell_sel, cell_we, mem_wipe_req;
   logic       mem_wipe_done = 1'b0;
   logic       mem_access_block, reset_phase, halt_watchdog_reset_opt;
   logic       watchdog_type_opt, clock_source_select, low_voltage_detector;
   logic       aux_voltage_detector, reset_cycle_select, input_halver;
   logic       readout_protect, package_reserved, motor_output_oe;
   logic       motor_output_level, halt_entry, watchdog_active;
   logic       halt_reset_req;
   logic [2:0] package_select;
   logic [7:0] cells [2];
   logic [1:0] got;
   logic [11:0] cfg;
   int         n_errors = 0, checked = 0, cycles = 0, wcnt = 0;
   bit         wiped = 0;
   localparam logic [7:0] T0 [4] = '{8'h00, 8'h2B, 8'hD4, 8'hBC};
   localparam logic [7:0] T1 [4] = '{8'h01, 8'h22, 8'h60, 8'h40};

   obc_loader i_dut (.clk, .rst, .prog_mode_pin, .test_mode_pin, .prog_req,
      .prog_cmd, .prog_sel, .prog_wdata, .prog_ack, .prog_err, .prog_rdata,
      .cell_sel, .cell_we, .cell_wdata, .cell_rdata, .mem_wipe_req,
      .mem_wipe_done, .mem_access_block, .reset_phase,
      .halt_watchdog_reset_opt, .watchdog_type_opt, .clock_source_select,
      .low_voltage_detector, .aux_voltage_detector, .reset_cycle_select,
      .input_halver, .readout_protect, .package_select, .package_reserved,
      .motor_output_oe, .motor_output_level, .halt_entry, .watchdog_active,
      .halt_reset_req);

   // settings gathered for one compare
   assign cfg = {halt_watchdog_reset_opt, watchdog_type_opt,
      clock_source_select, low_voltage_detector, aux_voltage_detector,
      reset_cycle_select, input_halver, readout_protect, package_select,
      package_reserved};
   // cell array model, read data follows select
   assign cell_rdata = cells[cell_sel];
   always @(posedge clk) if (cell_we) cells[cell_sel] <= cell_wdata;
   // wiper answers a held request after a few cycles
   always @(negedge clk) begin
      wcnt <= mem_wipe_req ? wcnt + 1 : 0;
      mem_wipe_done <= mem_wipe_req && wcnt > 6;
      if (mem_wipe_req) wiped <= 1'b1;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 40000) begin
         n_errors++;
         $display("MISMATCH timeout expected end seen hang");
         end_sim();
      end
   end

   function automatic logic [11:0] exp_cfg(logic [7:0] a, logic [7:0] b);
      return {a[7], !a[6], !a[5], a[4:3] < 2'h2, a[4:3] == 2'h0,
         !a[5] || !a[2], !a[1], !a[0], b[7:5], b[7:5] > 3'h1};
   endfunction : exp_cfg

   task automatic check(string name, logic [19:0] exp, logic [19:0] seen);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one programmer command, waits for ack or refusal
   task automatic prog(obc_cmd_e c, logic s, logic [7:0] d);
      @(negedge clk);
      prog_req = 1'b1;
      prog_cmd = c;
      prog_sel = s;
      prog_wdata = d;
      got = 2'b00;
      for (int i = 0; i < 100 && got == 2'b00; i++) begin
         @(negedge clk);
         prog_req = 1'b0;
         got = {prog_ack, prog_err};
      end
   endtask : prog

   // load bytes through a reset and check phase length and decode
   task automatic boot(logic [7:0] a, logic [7:0] b);
      int n;
      int len;
      logic [1:0] motor_output_reset_state;
      cells[0] = a;
      cells[1] = b;
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      n = 0;
      len = (!a[5] || !a[2]) ? RPH_LONG : RPH_SHORT;
      motor_output_reset_state = 2'bxx;
      while (reset_phase !== 1'b0 && n < 5000) begin
         @(negedge clk);
         n++;
         if (n == 8) motor_output_reset_state = {motor_output_oe, motor_output_oe & motor_output_level};
      end
      check("mco", (b[0] ^ b[1]) ? {1'b1, b[1]} : 2'b00, motor_output_reset_state);
      check("cfg", exp_cfg(a, b), cfg);
      check("phase_len", 1, n >= len && n <= len + 8);
      @(negedge clk);
      halt_entry = 1'b1;
      @(negedge clk);
      halt_entry = 1'b0;
      check("halt_reset_req", a[7], halt_reset_req);
      test_mode_pin = 1'b1;
      repeat (4) @(negedge clk);
      check("mem_access_block", !a[0], mem_access_block);
      test_mode_pin = 1'b0;
      $display("boot %h %h done", a, b);
   endtask : boot

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      {prog_mode_pin, test_mode_pin, prog_req, prog_sel} = 4'h0;
      {halt_entry, prog_wdata} = 9'h000;
      watchdog_active = 1'b1;
      prog_cmd = OBC_CMD_READ;
      boot(8'hFF, 8'hFF);
      prog_mode_pin = 1'b1;
      repeat (4) @(negedge clk);
      prog(OBC_CMD_WRITE, 1'b0, 8'h2B);
      prog(OBC_CMD_WRITE, 1'b1, 8'h22);
      @(negedge clk);
      check("byte1", 8'h22, cells[1]);
      prog(OBC_CMD_READ, 1'b0, 8'h00);
      check("rdata", {2'b10, 8'h2B}, {got, prog_rdata});
      check("frozen", exp_cfg(8'hFF, 8'hFF), cfg);
      prog(OBC_CMD_ERASE, 1'b0, 8'h00);
      @(negedge clk);
      check("erase", {2'b10, 16'hFFFF, 1'b0}, {got, cells[0], cells[1], wiped});
      prog(obc_cmd_e'(2'h3), 1'b0, 8'h00);
      check("bad_cmd", 2'b01, got);
      prog_mode_pin = 1'b0;
      repeat (4) @(negedge clk);
      prog(OBC_CMD_READ, 1'b0, 8'h00);
      check("no_prog_mode", 2'b01, got);
      $display("programmer test done");
      for (int k = 0; k < 4; k++) boot(T0[k], T1[k]);
      prog_mode_pin = 1'b1;
      repeat (4) @(negedge clk);
      prog(OBC_CMD_ERASE, 1'b0, 8'h00);
      @(negedge clk);
      check("wipe_erase", {2'b10, 16'hFFFF, 1'b1}, {got, cells[0], cells[1], wiped});
      $display("protected erase test done");
      end_sim();
   end
endmodule : obc_loader_tb_top
